/* File: include/power_up_cfg.svh */
`ifndef POWER_UP_CFG_SVH
`define POWER_UP_CFG_SVH

// System clock period
`define MCLK_PERIOD_NS    40
// Longest wait for a power-up decision before falling back to two-wire
`define PU_WINDOW_NS      100000
`define PU_WINDOW_CYC     ((`PU_WINDOW_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
// Link clock edges that count as a running clock (well below 400)
`define CLK_ACTIVE_EDGES  64
// Serial clock pulses the host gives before its first command
`define SYNC_WAKE_PULSES  5
// Link clocks per elementary time unit of the character link
`define ETU_CLOCKS        372
// Character frame: start, 8 data, parity, 2 guard
`define CHAR_BITS         12
`define ATR_BYTES         8
// Factory transport code, same as password set seven write code
`define TCODE_INIT        24'hdd4297
`define TCODE_W           24

`endif

/* File: include/power_up_pkg.sv */
package power_up_pkg;

  // Gray coded along window -> hold -> run; window -> sync is one bit too
  typedef enum logic [2:0] {
    ST_WINDOW = 3'h0,
    ST_HOLD   = 3'h1,
    ST_RUN    = 3'h3,
    ST_SYNC   = 3'h4
  } pu_state_t;

endpackage : power_up_pkg

/* File: logic/atr_sender.sv */
`include "power_up_cfg.svh"

module atr_sender #(
  // Arbitrary answer bytes; last bytes are the density-coded history
  parameter logic [63:0] ATR_VALUE = 64'h3b_b2_11_00_10_80_00_01
) (
  input  wire logic linkClk,   // Link clock
  input  wire logic linkRst_n, // Link-domain synchronous reset
  input  wire logic start,     // One-cycle pulse: send the answer
  output logic      ioOe,      // Open-drain enable, high pulls line low
  output logic      ioOut,     // Driven level, always low
  output logic      done       // Answer fully sent
);

  logic [7:0] atrByte [`ATR_BYTES];
  logic       busy_reg;
  logic [2:0] byteIdx_reg;
  logic [3:0] bitIdx_reg;
  logic [8:0] etuCnt_reg;
  logic [7:0] curByte;
  logic       bitVal;

  // Split the answer into bytes, first byte on the top
  for (genvar g = 0; g < `ATR_BYTES; g++) begin : g_byte
    assign atrByte[g] = ATR_VALUE[63 - 8 * g -: 8];
  end

  assign curByte = atrByte[byteIdx_reg];

  // Frame bit: start low, data LSB first, even parity, guard released
  always_comb begin
    case (bitIdx_reg)
      4'h0:    bitVal = 1'b0;
      4'h9:    bitVal = ^curByte;
      4'ha,
      4'hb:    bitVal = 1'b1;
      default: bitVal = curByte[3'(bitIdx_reg - 4'h1)];
    endcase
  end

  // Bit timing and character sequencing; a new start restarts the answer
  always_ff @(posedge linkClk) begin
    if (!linkRst_n) begin
      busy_reg    <= 1'b0;
      byteIdx_reg <= 3'h0;
      bitIdx_reg  <= 4'h0;
      etuCnt_reg  <= 9'h000;
      done        <= 1'b0;
    end else if (start) begin
      busy_reg    <= 1'b1;
      byteIdx_reg <= 3'h0;
      bitIdx_reg  <= 4'h0;
      etuCnt_reg  <= 9'h000;
      done        <= 1'b0;
    end else if (busy_reg) begin
      if (etuCnt_reg == 9'(`ETU_CLOCKS - 1)) begin
        etuCnt_reg <= 9'h000;
        if (bitIdx_reg == 4'(`CHAR_BITS - 1)) begin
          bitIdx_reg <= 4'h0;
          if (byteIdx_reg == 3'(`ATR_BYTES - 1)) begin
            busy_reg <= 1'b0;
            done     <= 1'b1;
          end else begin
            byteIdx_reg <= byteIdx_reg + 3'h1;
          end
        end else begin
          bitIdx_reg <= bitIdx_reg + 4'h1;
        end
      end else begin
        etuCnt_reg <= etuCnt_reg + 9'h001;
      end
    end
  end

  // Open-drain line: only a zero is driven, a one is left to the pull-up
  always_ff @(posedge linkClk) begin
    if (!linkRst_n) begin
      ioOe  <= 1'b0;
      ioOut <= 1'b0;
    end else begin
      ioOe  <= busy_reg && !bitVal;
      ioOut <= 1'b0;
    end
  end

  default clocking cb @(posedge linkClk); endclocking
  default disable iff (!linkRst_n);

  a_start_bit_low: assert property (start |-> ##2 ioOe)
    else $error("start bit not driven low");
  a_guard_free: assert property (
    (busy_reg && bitIdx_reg >= 4'ha) |=> !ioOe)
    else $error("line driven during guard time");
  a_done_clears: assert property (start |=> !done && busy_reg)
    else $error("answer start did not clear done");

endmodule : atr_sender

/* File: logic/transport_code_gate.sv */
`include "power_up_cfg.svh"

module transport_code_gate (
  input  wire logic                mclk,          // System clock
  input  wire logic                rst_n,         // Sync reset, active low
  input  wire logic                presentStb,    // Code presentation pulse
  input  wire logic [`TCODE_W-1:0] presentCode,   // Presented code
  input  wire logic                rewriteStb,    // Code rewrite pulse
  input  wire logic [`TCODE_W-1:0] rewriteCode,   // New code value
  input  wire logic                cfgWriteStb,   // Config write request
  input  wire logic                fuseBlowStb,   // Fuse blow request
  output logic                     accessGranted, // Config memory open
  output logic                     fusesBlown,    // Config locked
  output logic                     cfgWriteAck,   // Write accepted pulse
  output logic                     cfgWriteDeny   // Write refused pulse
);

  logic [`TCODE_W-1:0] code_reg;
  logic                writeOk;
  logic                rewriteSeen_reg;

  assign writeOk = accessGranted && !fusesBlown;

  // Check helper: no rewrite asked for since reset, factory code still holds
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rewriteSeen_reg <= 1'b0;
    end else if (rewriteStb) begin
      rewriteSeen_reg <= 1'b1;
    end
  end

  // Stored code; only a holder of the current code may replace it
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      code_reg <= `TCODE_INIT;
    end else if (rewriteStb && accessGranted) begin
      code_reg <= rewriteCode;
    end
  end

  // A wrong presentation also closes access again
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      accessGranted <= 1'b0;
    end else if (presentStb) begin
      accessGranted <= (presentCode == code_reg);
    end
  end

  // Fuses are one way; blowing needs open access
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      fusesBlown <= 1'b0;
    end else if (fuseBlowStb && accessGranted) begin
      fusesBlown <= 1'b1;
    end
  end

  // Config writes need the code and unblown fuses
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfgWriteAck  <= 1'b0;
      cfgWriteDeny <= 1'b0;
    end else begin
      cfgWriteAck  <= cfgWriteStb && writeOk;
      cfgWriteDeny <= cfgWriteStb && !writeOk;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_deny_no_code: assert property (
    (cfgWriteStb && !accessGranted) |=> cfgWriteDeny && !cfgWriteAck)
    else $error("config write passed without code");
  a_factory_code: assert property (
    (!rewriteSeen_reg && presentStb && presentCode == `TCODE_INIT)
    |=> accessGranted)
    else $error("factory code not accepted");
  a_rewrite_code: assert property (
    (rewriteStb && accessGranted && !presentStb) ##1
    (!presentStb && !rewriteStb) ##1
    (presentStb && presentCode == $past(rewriteCode, 2) && !rewriteStb)
    |=> accessGranted)
    else $error("rewritten code not accepted");
  a_fuse_locks: assert property (
    (fusesBlown && cfgWriteStb) |=> !cfgWriteAck ##1 fusesBlown)
    else $error("config write after fuses blown");

endmodule : transport_code_gate

/* File: logic/power_up_protocol_select.sv */
`include "power_up_cfg.svh"

module power_up_protocol_select (
  input  wire logic                mclk,           // System clock, 25 MHz
  input  wire logic                rst_n,          // Power-on reset
  input  wire logic                linkClk,        // Serial/card clock pin
  input  wire logic                resetPinLevel,  // Reset pin level
  input  wire logic                resetPinDriven, // Reset pin is driven
  input  wire logic                presentStb,     // Present transport code
  input  wire logic [`TCODE_W-1:0] presentCode,    // Presented code
  input  wire logic                rewriteStb,     // Rewrite transport code
  input  wire logic [`TCODE_W-1:0] rewriteCode,    // New transport code
  input  wire logic                cfgWriteStb,    // Config write request
  input  wire logic                fuseBlowStb,    // Blow security fuses
  output logic                     modeSync,       // Two-wire mode chosen
  output logic                     modeAsync,      // Card mode chosen
  output logic                     cmdReady,       // Wake pulses seen
  output logic                     atrDone,        // Answer sent
  output logic                     ioOe,           // Data pin pull-low
  output logic                     ioOut,          // Data pin level
  output logic                     accessGranted,  // Config memory open
  output logic                     fusesBlown,     // Config locked
  output logic                     cfgWriteAck,    // Write accepted
  output logic                     cfgWriteDeny    // Write refused
);

  power_up_pkg::pu_state_t state_reg;
  power_up_pkg::pu_state_t state_next;

  logic [1:0]  pinS1_reg;
  logic [1:0]  pinS2_reg;
  logic        rstLevel;
  logic [11:0] winCnt_reg;
  logic        winEnd;
  logic        atrReqTgl_reg;
  logic        clkSeenS1_reg;
  logic        clkSeenS2_reg;
  logic        readyS1_reg;
  logic        readyS2_reg;
  logic        doneS1_reg;
  logic        doneS2_reg;

  logic        linkRstS1_reg;
  logic        linkRst_n;
  logic        syncS1_reg;
  logic        syncS2_reg;
  logic        tglS1_reg;
  logic        tglS2_reg;
  logic        tglS3_reg;
  logic        atrStart;
  logic [6:0]  edgeCnt_reg;
  logic        clkSeenLink_reg;
  logic [2:0]  wakeCnt_reg;
  logic        readyLink_reg;
  logic        atrDoneLink;

  // Reset pin and its drive flag each pass two flops before use
  // No reset here: a preset level would fake a high pin at release
  always_ff @(posedge mclk) begin
    pinS1_reg <= {resetPinDriven, resetPinLevel};
    pinS2_reg <= pinS1_reg;
  end

  // Internal pull-up: an undriven pin is seen as high
  assign rstLevel = pinS2_reg[1] ? pinS2_reg[0] : 1'b1;

  // Decision window timer; expiry without card entry falls back to two-wire
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      winCnt_reg <= 12'h000;
    end else if (state_reg == power_up_pkg::ST_WINDOW && !winEnd) begin
      winCnt_reg <= winCnt_reg + 12'h001;
    end
  end

  assign winEnd = (winCnt_reg == 12'(`PU_WINDOW_CYC - 1));

  // Mode choice; the chosen branch never leads back to the window
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      power_up_pkg::ST_WINDOW: begin
        if (rstLevel) begin
          state_next = power_up_pkg::ST_SYNC;
        end else if (clkSeenS2_reg) begin
          state_next = power_up_pkg::ST_HOLD;
        end else if (winEnd) begin
          state_next = power_up_pkg::ST_SYNC;
        end
      end
      power_up_pkg::ST_HOLD: begin
        if (rstLevel) begin
          state_next = power_up_pkg::ST_RUN;
        end
      end
      power_up_pkg::ST_RUN: begin
        if (!rstLevel) begin
          state_next = power_up_pkg::ST_HOLD;
        end
      end
      power_up_pkg::ST_SYNC: begin
        state_next = power_up_pkg::ST_SYNC;
      end
      default: begin
        state_next = power_up_pkg::ST_SYNC;
      end
    endcase
  end

  // State only ever restarts on power-on reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= power_up_pkg::ST_WINDOW;
    end else begin
      state_reg <= state_next;
    end
  end

  // Mode flags follow the next state so they appear with the transition
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      modeSync  <= 1'b0;
      modeAsync <= 1'b0;
    end else begin
      modeSync  <= (state_next == power_up_pkg::ST_SYNC);
      modeAsync <= (state_next == power_up_pkg::ST_HOLD) ||
                   (state_next == power_up_pkg::ST_RUN);
    end
  end

  // Each reset release in card mode asks for a fresh answer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      atrReqTgl_reg <= 1'b0;
    end else if (state_reg == power_up_pkg::ST_HOLD && rstLevel) begin
      atrReqTgl_reg <= !atrReqTgl_reg;
    end
  end

  // Link-domain levels brought back to the system clock
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      clkSeenS1_reg <= 1'b0;
      clkSeenS2_reg <= 1'b0;
      readyS1_reg   <= 1'b0;
      readyS2_reg   <= 1'b0;
      doneS1_reg    <= 1'b0;
      doneS2_reg    <= 1'b0;
    end else begin
      clkSeenS1_reg <= clkSeenLink_reg;
      clkSeenS2_reg <= clkSeenS1_reg;
      readyS1_reg   <= readyLink_reg;
      readyS2_reg   <= readyS1_reg;
      doneS1_reg    <= atrDoneLink;
      doneS2_reg    <= doneS1_reg;
    end
  end

  // Status outputs, qualified by the mode they belong to
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmdReady <= 1'b0;
      atrDone  <= 1'b0;
    end else begin
      cmdReady <= readyS2_reg && modeSync;
      atrDone  <= doneS2_reg && modeAsync;
    end
  end

  // Link reset derived from the power-on reset; needs link edges to act
  always_ff @(posedge linkClk) begin
    linkRstS1_reg <= rst_n;
    linkRst_n     <= linkRstS1_reg;
  end

  // Mode level and answer request cross into the link domain
  always_ff @(posedge linkClk) begin
    if (!linkRst_n) begin
      syncS1_reg <= 1'b0;
      syncS2_reg <= 1'b0;
      tglS1_reg  <= 1'b0;
      tglS2_reg  <= 1'b0;
      tglS3_reg  <= 1'b0;
    end else begin
      syncS1_reg <= modeSync;
      syncS2_reg <= syncS1_reg;
      tglS1_reg  <= atrReqTgl_reg;
      tglS2_reg  <= tglS1_reg;
      tglS3_reg  <= tglS2_reg;
    end
  end

  assign atrStart = tglS2_reg ^ tglS3_reg;

  // Running-clock detector; the threshold sits far below the 400-clock hold
  always_ff @(posedge linkClk) begin
    if (!linkRst_n) begin
      edgeCnt_reg     <= 7'h00;
      clkSeenLink_reg <= 1'b0;
    end else if (edgeCnt_reg != 7'(`CLK_ACTIVE_EDGES)) begin
      edgeCnt_reg <= edgeCnt_reg + 7'h01;
    end else begin
      clkSeenLink_reg <= 1'b1;
    end
  end

  // Count host wake pulses once two-wire mode is known on this side
  always_ff @(posedge linkClk) begin
    if (!linkRst_n) begin
      wakeCnt_reg   <= 3'h0;
      readyLink_reg <= 1'b0;
    end else if (syncS2_reg) begin
      if (wakeCnt_reg != 3'(`SYNC_WAKE_PULSES)) begin
        wakeCnt_reg <= wakeCnt_reg + 3'h1;
      end else begin
        readyLink_reg <= 1'b1;
      end
    end
  end

  // Character transmitter for the answer to reset
  atr_sender atr_sender_i (
    .linkClk   (linkClk),
    .linkRst_n (linkRst_n),
    .start     (atrStart),
    .ioOe      (ioOe),
    .ioOut     (ioOut),
    .done      (atrDoneLink)
  );

  // Transport-code protection of the configuration memory
  transport_code_gate transport_code_gate_i (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .presentStb    (presentStb),
    .presentCode   (presentCode),
    .rewriteStb    (rewriteStb),
    .rewriteCode   (rewriteCode),
    .cfgWriteStb   (cfgWriteStb),
    .fuseBlowStb   (fuseBlowStb),
    .accessGranted (accessGranted),
    .fusesBlown    (fusesBlown),
    .cfgWriteAck   (cfgWriteAck),
    .cfgWriteDeny  (cfgWriteDeny)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_mode_kept: assert property (
    (state_reg != power_up_pkg::ST_WINDOW)
    |=> state_reg != power_up_pkg::ST_WINDOW)
    else $error("protocol choice reopened");
  a_default_sync: assert property (
    (state_reg == power_up_pkg::ST_WINDOW && winEnd && !clkSeenS2_reg)
    |=> modeSync && !modeAsync)
    else $error("window expiry did not pick two-wire");
  a_pullup_sync: assert property (
    ((!resetPinDriven)[*3] ##0 (state_reg == power_up_pkg::ST_WINDOW))
    |=> modeSync)
    else $error("undriven reset pin did not pick two-wire");
  a_sync_locked: assert property (
    modeSync |=> modeSync && !modeAsync ##1 modeSync)
    else $error("two-wire mode left");
  a_async_locked: assert property (
    modeAsync |=> modeAsync && !modeSync)
    else $error("card mode left");
  a_async_select: assert property (
    (state_reg == power_up_pkg::ST_WINDOW && !rstLevel && clkSeenS2_reg)
    |=> modeAsync)
    else $error("reset low with clock did not pick card mode");
  a_atr_request: assert property (
    (state_reg == power_up_pkg::ST_HOLD && rstLevel)
    |=> atrReqTgl_reg != $past(atrReqTgl_reg))
    else $error("reset release raised no answer request");
  a_ready_mode: assert property (cmdReady |-> modeSync)
    else $error("command ready outside two-wire mode");

  c_sync_ready: cover property ($rose(cmdReady));
  c_atr_done: cover property ($rose(atrDone));
  c_warm_reset: cover property (
    state_reg == power_up_pkg::ST_RUN ##1 state_reg == power_up_pkg::ST_HOLD);
  c_fuse_lock: cover property (fusesBlown && cfgWriteDeny);

endmodule : power_up_protocol_select

/* File: bench/card_reader_model.sv */
// Host or card reader on the far side of the clock, reset and data pins
module card_reader_model (
  output logic      linkClk,        // Clock pin, still outside frames
  output logic      resetPinLevel,  // Level put on the reset pin
  output logic      resetPinDriven, // Reset pin driven, else pulled up
  input  wire logic ioOe,           // Device pulls the data line low
  input  wire logic ioOut           // Device data level, unused here
);
  timeunit 1ns;
  timeprecision 100ps;

  logic run;
  logic ck;

  // Gated clock, odd offset so it never lines up with the system clock
  initial begin
    run = 1'b0;
    ck = 1'b0;
    resetPinLevel = 1'b1;
    resetPinDriven = 1'b0;
    #3;
    forever #7.5 ck = run ? ~ck : 1'b0;
  end
  assign linkClk = ck;

  // A released pin reads high through the device's pull-up
  task setPin(input logic lvl, input logic drv);
    resetPinDriven = drv;
    resetPinLevel = drv ? lvl : 1'b1;
  endtask : setPin

  // Burst of clock pulses, then the clock stands still again
  task pulses(input int n);
    run = 1'b1;
    repeat (n) @(posedge ck);
    @(negedge ck);
    run = 1'b0;
  endtask : pulses

  task halt();
    @(negedge ck);
    run = 1'b0;
  endtask : halt

  // Cold reset: pins already low, clock runs, reset rises 400 clocks later
  task cardCold();
    run = 1'b1;
    repeat (400) @(posedge ck);
    resetPinLevel = 1'b1;
  endtask : cardCold

  // Receive one character, sampled mid-bit; ok means start and even parity
  task getChar(output logic [7:0] b, output logic ok);
    logic [8:0] bits;
    int i;
    for (i = 0; i < 3000 && ioOe !== 1'b1; i++) @(posedge ck);
    ok = (ioOe === 1'b1);
    repeat (186) @(posedge ck);
    for (i = 0; i < 9; i++) begin
      repeat (372) @(posedge ck);
      bits[i] = ~ioOe;
    end
    b = bits[7:0];
    ok = ok && ((^bits) === 1'b0);
  endtask : getChar
endmodule : card_reader_model

/* File: bench/power_up_protocol_select_test.sv */
`include "power_up_cfg.svh"

`define CHK(nm, exp, got) begin cmp_count++; \
  if ((got) !== (exp)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end

`define WAITF(c, n) begin int k; \
  for (k = 0; k < n && !(c); k++) @(negedge mclk); \
  if (!(c)) begin err_count++; \
  $display("ERROR wait ran out"); finish_test(); end end

module power_up_protocol_select_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic                mclk;
  logic                rst_n;
  logic                linkClk;
  logic                resetPinLevel;
  logic                resetPinDriven;
  logic                presentStb;
  logic [`TCODE_W-1:0] presentCode;
  logic                rewriteStb;
  logic [`TCODE_W-1:0] rewriteCode;
  logic                cfgWriteStb;
  logic                fuseBlowStb;
  logic                modeSync;
  logic                modeAsync;
  logic                cmdReady;
  logic                atrDone;
  logic                ioOe;
  logic                ioOut;
  logic                accessGranted;
  logic                fusesBlown;
  logic                cfgWriteAck;
  logic                cfgWriteDeny;
  int                  err_count = 0;
  int                  cmp_count = 0;

  power_up_protocol_select power_up_protocol_select_i (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .linkClk        (linkClk),
    .resetPinLevel  (resetPinLevel),
    .resetPinDriven (resetPinDriven),
    .presentStb     (presentStb),
    .presentCode    (presentCode),
    .rewriteStb     (rewriteStb),
    .rewriteCode    (rewriteCode),
    .cfgWriteStb    (cfgWriteStb),
    .fuseBlowStb    (fuseBlowStb),
    .modeSync       (modeSync),
    .modeAsync      (modeAsync),
    .cmdReady       (cmdReady),
    .atrDone        (atrDone),
    .ioOe           (ioOe),
    .ioOut          (ioOut),
    .accessGranted  (accessGranted),
    .fusesBlown     (fusesBlown),
    .cfgWriteAck    (cfgWriteAck),
    .cfgWriteDeny   (cfgWriteDeny)
  );

  card_reader_model card_reader_model_i (
    .linkClk        (linkClk),
    .resetPinLevel  (resetPinLevel),
    .resetPinDriven (resetPinDriven),
    .ioOe           (ioOe),
    .ioOut          (ioOut)
  );

  // System clock, 40 ns
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;

  task finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // Link clock runs during reset so the link-side flops settle too
  task powerCycle(input logic lvl, input logic drv);
    @(negedge mclk);
    rst_n = 1'b0;
    card_reader_model_i.setPin(lvl, drv);
    fork
      card_reader_model_i.pulses(8);
    join_none
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
  endtask : powerCycle

  // One strobe cycle on the code gate; k = fuse, write, rewrite, present
  task op(input logic [3:0] k, input logic [`TCODE_W-1:0] c);
    @(negedge mclk);
    {fuseBlowStb, cfgWriteStb, rewriteStb, presentStb} = k;
    presentCode = c;
    rewriteCode = c;
    @(negedge mclk);
    {fuseBlowStb, cfgWriteStb, rewriteStb, presentStb} = 4'h0;
  endtask : op

  // Floating reset pin gives two-wire mode, and it survives a card entry
  task test_sync();
    powerCycle(1'b0, 1'b0);
    `WAITF(modeSync === 1'b1, 20)
    `CHK("modeAsync", 1'b0, modeAsync)
    card_reader_model_i.pulses(12);
    `WAITF(cmdReady === 1'b1, 20)
    `CHK("cmdReady", 1'b1, cmdReady)
    card_reader_model_i.setPin(1'b0, 1'b1);
    card_reader_model_i.cardCold();
    card_reader_model_i.halt();
    repeat (100) @(negedge mclk);
    `CHK("modeAsync", 1'b0, modeAsync)
    `CHK("modeSync", 1'b1, modeSync)
    `CHK("atrDone", 1'b0, atrDone)
    $display("test sync done");
  endtask : test_sync

  // Reset pin driven low with a still clock: window runs out to two-wire
  task test_expiry();
    powerCycle(1'b0, 1'b1);
    repeat (2000) @(negedge mclk);
    `CHK("modeSync", 1'b0, modeSync)
    `WAITF(modeSync === 1'b1, 1000)
    `CHK("modeAsync", 1'b0, modeAsync)
    $display("test expiry done");
  endtask : test_expiry

  // Transport code gate: deny, grant, rewrite, fuse lock
  task test_gate();
    op(4'h4, 24'h000000);
    `CHK("cfgWriteDeny", 1'b1, cfgWriteDeny)
    op(4'h1, 24'h123456);
    `CHK("accessGranted", 1'b0, accessGranted)
    op(4'h1, 24'hdd4297);
    `CHK("accessGranted", 1'b1, accessGranted)
    op(4'h4, 24'h000000);
    `CHK("cfgWriteAck", 1'b1, cfgWriteAck)
    op(4'h2, 24'h5a5a5a);
    op(4'h1, 24'h5a5a5a);
    `CHK("accessGranted", 1'b1, accessGranted)
    op(4'h1, 24'hdd4297);
    `CHK("accessGranted", 1'b0, accessGranted)
    op(4'h1, 24'h5a5a5a);
    `CHK("accessGranted", 1'b1, accessGranted)
    op(4'h8, 24'h000000);
    `CHK("fusesBlown", 1'b1, fusesBlown)
    op(4'h4, 24'h000000);
    `CHK("cfgWriteDeny", 1'b1, cfgWriteDeny)
    $display("test gate done");
  endtask : test_gate

  // Card cold reset, first answer character, then a refused mode change
  task test_card();
    logic [7:0] b;
    logic       ok;
    powerCycle(1'b0, 1'b1);
    card_reader_model_i.cardCold();
    card_reader_model_i.getChar(b, ok);
    `CHK("modeAsync", 1'b1, modeAsync)
    `CHK("modeSync", 1'b0, modeSync)
    `CHK("firstChar", 8'h3b, b)
    `CHK("charFrame", 1'b1, ok)
    `CHK("ioOut", 1'b0, ioOut)
    `WAITF(atrDone === 1'b1, 16000)
    `CHK("atrDone", 1'b1, atrDone)
    card_reader_model_i.setPin(1'b0, 1'b0);
    repeat (50) @(negedge mclk);
    `CHK("modeSync", 1'b0, modeSync)
    `CHK("modeAsync", 1'b1, modeAsync)
    `CHK("cmdReady", 1'b0, cmdReady)
    card_reader_model_i.halt();
    $display("test card done");
  endtask : test_card

  initial begin
    rst_n = 1'b0;
    presentStb = 1'b0;
    presentCode = 24'h000000;
    rewriteStb = 1'b0;
    rewriteCode = 24'h000000;
    cfgWriteStb = 1'b0;
    fuseBlowStb = 1'b0;
    test_sync();
    test_expiry();
    test_gate();
    test_card();
    finish_test();
  end
endmodule : power_up_protocol_select_test
